//--- verilog/amd_pkg.sv
// constants for the accumulator motion command decoder
package amd_pkg;
    localparam logic [7:0] OP_MOVE_POS_IDX    = 8'h2F; // 47
    localparam logic [7:0] OP_ROT_LEFT        = 8'h32; // 50
    localparam logic [7:0] OP_ROT_RIGHT       = 8'h33; // 51
    localparam logic [7:0] OP_ROT_LEFT_IDX    = 8'h34; // 52
    localparam logic [7:0] OP_ROT_RIGHT_IDX   = 8'h35; // 53
    localparam logic [7:0] MODE_ABSOLUTE      = 8'h00;
    localparam logic [7:0] MODE_RELATIVE      = 8'h01;
    localparam logic [7:0] MODE_STORED_POINT  = 8'h02;
    localparam logic [7:0] STATUS_OK          = 8'h64; // 100
    localparam logic [7:0] STATUS_BAD_SUM     = 8'h01;
    localparam logic [7:0] STATUS_BAD_CMD     = 8'h02;
    localparam logic [7:0] STATUS_BAD_TYPE    = 8'h03;
    localparam logic [7:0] STATUS_BAD_VALUE   = 8'h04;
    localparam logic [7:0] PARAM_TARGET_POS   = 8'h00; // #0
    localparam logic [7:0] PARAM_TARGET_VEL   = 8'h02; // #2
    localparam logic [7:0] AXIS_LAST          = 8'h05;
    localparam logic [3:0] FRAME_LAST         = 4'h8;  // nine bytes, index 0..8
    localparam logic [3:0] BYTE_ADDR          = 4'h0;
    localparam logic [3:0] BYTE_OPCODE        = 4'h1;
    localparam logic [3:0] BYTE_TYPE          = 4'h2;
    localparam logic [3:0] BYTE_MOTOR         = 4'h3;
    localparam logic [3:0] BYTE_VAL3          = 4'h4;
    localparam logic [2:0] AX_MODE_VELOCITY   = 3'h0;
    localparam logic [2:0] AX_MODE_POS_ABS    = 3'h1;
    localparam logic [2:0] AX_MODE_POS_REL    = 3'h2;
    localparam logic [2:0] AX_MODE_POS_POINT  = 3'h3;
    typedef enum logic [2:0] {
        ST_RECV, ST_CHECK, ST_SET_MODE, ST_SET_PARAM, ST_REPLY
    } amd_state_t;
endpackage : amd_pkg

//--- verilog/amd_decoder.sv
// command frame decoder and axis parameter writer for accumulator motion commands
// What this block does
// - opcode 50 starts left rotation of motor field axis at accumulator speed.
// - opcode 51 starts right rotation of motor field axis at accumulator speed.
// - rotate commands select velocity mode first, then write accumulator to parameter 2.
// - rotation speed in accumulator counts microsteps per second.
// - left rotation decrements position counter, right rotation increments it.
// - opcodes 52/53 rotate left/right on index-register axis, ignoring other fields.
// - opcode 47 moves index-register axis; type 0 absolute, 1 relative, 2 point.
// - indexed move writes accumulator into target position parameter 0.
// - relative adds accumulator to actual position; point mode uses stored coordinate.
// - reply right after move setup; further commands accepted immediately.
// - a later rotate command on the same axis aborts a positioning move.
// - frame is address, opcode, type, motor, four value bytes msb first, checksum.
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------------------
// overview
// ------------------------------------------------------------
// frames arrive one byte per edge while rx_valid_in is high.
// bytes offered while busy_out is high are dropped silently,
// so the host waits for the reply before it starts the next frame.
// timing after the edge that takes the checksum byte (edge e):
//   e+1  check cycle: sum, opcode, type and axis are judged
//   e+2  mode_wr_out pulses with axis_mode_out and dir_left_out
//   e+3  axis_wr_out pulses with param_num_out and param_val_out
//   e+4  reply_out pulses with status 100 and busy_out falls
// a refused frame skips both writes and replies at e+2 instead.
// the mode write always leads the parameter write by one cycle,
// so an axis never sees a new speed while still in position mode.
// the accumulator is sampled in the parameter cycle, not at the
// end of the frame: a host that changes it late gets the newer value.
// relative and stored-point arithmetic is left to the axis; this
// block only passes the mode code and the raw accumulator on.
// the address byte is summed but not filtered; every address is served.
// error codes: 1 bad sum, 2 unknown opcode, 3 bad type, 4 bad axis.
// checks run in a fixed order (sum, opcode, type, axis), and the
// first failure names the status; later faults are not reported.
// limitations:
// the stop command and the coordinate store are not decoded here
// and answer as unknown opcodes.
// aborting a move is simply the velocity-mode write that any
// rotate on that axis makes; no separate abort strobe exists.
// the index register is judged whole, so a large value is refused
// rather than folded onto an axis by truncation.
// the sum register is cleared by reset and in the reply cycle, so a reset in mid
// frame and a finished frame both restart with a clean sum.
// trade-off: one frame at a time keeps the logic small, at the cost
// of a four-cycle gap after an accepted frame and a two-cycle gap after a refused one.
module amd_decoder
    import amd_pkg::*;
(
    input  wire logic        core_clk_in,    // 50 MHz clock
    input  wire logic        rst_n_in,       // async reset, active low
    input  wire logic        rx_valid_in,    // one frame byte offered
    input  wire logic [7:0]  rx_byte_in,     // frame byte
    input  wire logic [31:0] accu_in,        // accumulator register
    input  wire logic [31:0] index_in,       // index register (axis number)
    output logic             axis_wr_out,    // one-cycle parameter write strobe
    output logic [2:0]       axis_sel_out,   // axis written
    output logic [7:0]       param_num_out,  // parameter number written
    output logic [31:0]      param_val_out,  // parameter value written
    output logic             mode_wr_out,    // one-cycle axis mode write strobe
    output logic [2:0]       axis_mode_out,  // new axis mode
    output logic             dir_left_out,   // rotation direction, 1 = left
    output logic             reply_out,      // one-cycle reply strobe
    output logic [7:0]       reply_status_out, // reply status code
    output logic             busy_out        // frame is being executed
);
    import amd_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    amd_state_t  state, next_state;
    logic [7:0]  frame [0:8];
    logic [7:0]  next_frame [0:8];
    logic [3:0]  cnt, next_cnt;
    logic [7:0]  sum, next_sum;
    logic        wr, next_wr, mwr, next_mwr, left, next_left, rep, next_rep;
    logic [2:0]  sel, next_sel, amode, next_amode;
    logic [7:0]  pnum, next_pnum, status, next_status;
    logic [31:0] pval, next_pval;

    // axis number valid check, used for direct and indexed axis fields
    function automatic logic axis_ok(input logic [31:0] a);
        axis_ok = (a <= 32'(AXIS_LAST));
    endfunction

    logic [7:0]  op;
    logic [7:0]  typ;
    logic [31:0] axis_src;
    logic        is_rot;
    logic        is_left;

    // ------------------------------------------------------------
    // opcode decoding
    // ------------------------------------------------------------
    // shared by the check, mode and parameter cycles
    function automatic logic op_is_rot(input logic [7:0] o);
        op_is_rot = (o == OP_ROT_LEFT) || (o == OP_ROT_RIGHT)
                 || (o == OP_ROT_LEFT_IDX) || (o == OP_ROT_RIGHT_IDX);
    endfunction

    function automatic logic op_is_left(input logic [7:0] o);
        op_is_left = (o == OP_ROT_LEFT) || (o == OP_ROT_LEFT_IDX);
    endfunction

    // only the two direct rotates read the motor byte
    function automatic logic op_is_direct(input logic [7:0] o);
        op_is_direct = (o == OP_ROT_LEFT) || (o == OP_ROT_RIGHT);
    endfunction

    // decoded fields of the frame held in the byte store
    assign op  = frame[BYTE_OPCODE];
    assign typ = frame[BYTE_TYPE];
    assign is_rot  = op_is_rot(op);
    assign is_left = op_is_left(op);
    // direct rotates take motor byte; indexed ones ignore type, motor, value
    assign axis_src = op_is_direct(op)
                    ? {24'h000000, frame[BYTE_MOTOR]} : index_in;

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb
    begin
        next_state  = state;
        next_frame  = frame;
        next_cnt    = cnt;
        next_sum    = sum;
        next_wr     = 1'b0;
        next_mwr    = 1'b0;
        next_rep    = 1'b0;
        next_left   = left;
        next_sel    = sel;
        next_amode  = amode;
        next_pnum   = pnum;
        next_pval   = pval;
        next_status = status;
        case (state)
            ST_RECV:
            begin
                // bytes fill in fixed order, value msb first
                if (rx_valid_in)
                begin
                    next_frame[cnt] = rx_byte_in;
                    if (cnt == FRAME_LAST)
                    begin
                        next_cnt   = BYTE_ADDR;
                        next_state = ST_CHECK;
                    end
                    else
                    begin
                        next_sum = sum + rx_byte_in; // mod-256 wraps by width
                        next_cnt = cnt + 4'h1;
                    end
                end
            end
            ST_CHECK:
            begin
                next_state = ST_REPLY;
                next_sel   = axis_src[2:0];
                if (frame[FRAME_LAST] != sum)
                    next_status = STATUS_BAD_SUM; // nothing executes on bad sum
                else if (is_rot)
                begin
                    if (!axis_ok(axis_src))
                        next_status = STATUS_BAD_VALUE; // no parameter touched
                    else
                    begin
                        next_status = STATUS_OK;
                        next_state  = ST_SET_MODE;
                    end
                end
                else if (op == OP_MOVE_POS_IDX)
                begin
                    if (typ > MODE_STORED_POINT)
                        next_status = STATUS_BAD_TYPE;
                    else if (!axis_ok(index_in))
                        next_status = STATUS_BAD_VALUE;
                    else
                    begin
                        next_status = STATUS_OK;
                        next_state  = ST_SET_MODE;
                    end
                end
                else
                    next_status = STATUS_BAD_CMD;
            end
            ST_SET_MODE:
            begin
                // mode goes first; a rotate here aborts any move on that axis
                next_mwr  = 1'b1;
                next_left = is_rot ? is_left : left; // left counts down, right up
                if (is_rot)
                    next_amode = AX_MODE_VELOCITY;
                else if (typ == MODE_RELATIVE)
                    next_amode = AX_MODE_POS_REL; // axis adds offset to actual
                else if (typ == MODE_STORED_POINT)
                    next_amode = AX_MODE_POS_POINT;
                else
                    next_amode = AX_MODE_POS_ABS;
                next_state = ST_SET_PARAM;
            end
            ST_SET_PARAM:
            begin
                // accumulator passes untouched: microsteps/s or target
                next_wr    = 1'b1;
                next_pval  = accu_in;
                next_pnum  = is_rot ? PARAM_TARGET_VEL : PARAM_TARGET_POS;
                next_state = ST_REPLY;
            end
            ST_REPLY:
            begin
                // answer without waiting for the motor
                next_rep   = 1'b1;
                next_sum   = 8'h00;
                next_state = ST_RECV;
            end
            default:
                next_state = ST_RECV;
        endcase
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            state  <= ST_RECV;
            for (int i = 0; i <= int'(FRAME_LAST); i++)
                frame[i] <= 8'h00;
            cnt    <= BYTE_ADDR;
            sum    <= 8'h00;
            wr     <= 1'b0;
            mwr    <= 1'b0;
            rep    <= 1'b0;
            left   <= 1'b0;
            sel    <= 3'h0;
            amode  <= AX_MODE_VELOCITY;
            pnum   <= 8'h00;
            pval   <= 32'h00000000;
            status <= STATUS_OK;
        end
        else
        begin
            state  <= next_state;
            frame  <= next_frame;
            cnt    <= next_cnt;
            sum    <= next_sum;
            wr     <= next_wr;
            mwr    <= next_mwr;
            rep    <= next_rep;
            left   <= next_left;
            sel    <= next_sel;
            amode  <= next_amode;
            pnum   <= next_pnum;
            pval   <= next_pval;
            status <= next_status;
        end
    end

    // busy is a registered copy so the output comes from a flip-flop
    logic busy;
    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            busy <= 1'b0;
        else
            busy <= (next_state != ST_RECV);
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // every output is a register copy; strobes last one cycle and
    // the data outputs hold until the next write of the same kind, but axis_sel_out and reply_status_out reload in every check cycle
    assign axis_wr_out      = wr;
    assign axis_sel_out     = sel;
    assign param_num_out    = pnum;
    assign param_val_out    = pval;
    assign mode_wr_out      = mwr;
    assign axis_mode_out    = amode;
    assign dir_left_out     = left;
    assign reply_out        = rep;
    assign reply_status_out = status;
    assign busy_out         = busy;
endmodule // amd_decoder
`default_nettype wire

//--- test/amd_host.sv
// host model: sends command frames byte by byte, fast or with idle gaps
`timescale 1ns/100ps
`default_nettype none
module amd_host
(
    input  wire logic       core_clk_in,  // bench clock
    input  wire logic       busy_in,      // decoder busy
    output logic            rx_valid_out, // byte offered
    output logic [7:0]      rx_byte_out   // frame byte
);
    initial
    begin
        rx_valid_out = 1'b0;
        rx_byte_out  = 8'h00;
    end
    // idle bytes are inverted so a stale byte never looks like a fresh one
    task automatic send(input logic [7:0] op, typ, mot, input int gap, input bit bad);
        logic [7:0] f [9];
        f = '{8'h01, op, typ, mot, 8'($urandom), 8'($urandom), 8'($urandom), 8'($urandom),
              8'h00};
        for (int i = 0; i < 8; i++) f[8] = f[8] + f[i];
        if (bad) f[8] = ~f[8];
        for (int w = 0; w < 20 && busy_in; w++) @(negedge core_clk_in);
        for (int i = 0; i < 9; i++)
        begin
            repeat (gap) @(negedge core_clk_in) {rx_valid_out, rx_byte_out} = {1'b0, ~rx_byte_out};
            @(negedge core_clk_in) {rx_valid_out, rx_byte_out} = {1'b1, f[i]};
        end
        @(negedge core_clk_in) {rx_valid_out, rx_byte_out} = {1'b0, ~rx_byte_out};
    endtask
endmodule // amd_host
`default_nettype wire

//--- test/amd_decoder_props.sv
// port assertions for the accumulator motion command decoder
`timescale 1ns/100ps
`default_nettype none
module amd_decoder_props
    import amd_pkg::*;
(
    input wire logic        core_clk_in,
    input wire logic        rst_n_in,
    input wire logic        rx_valid_in,
    input wire logic [7:0]  rx_byte_in,
    input wire logic [31:0] accu_in,
    input wire logic [31:0] index_in,
    input wire logic        axis_wr_out,
    input wire logic [2:0]  axis_sel_out,
    input wire logic [7:0]  param_num_out,
    input wire logic [31:0] param_val_out,
    input wire logic        mode_wr_out,
    input wire logic [2:0]  axis_mode_out,
    input wire logic        dir_left_out,
    input wire logic        reply_out,
    input wire logic [7:0]  reply_status_out,
    input wire logic        busy_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);
    AST_MODE_FIRST: assert property (axis_wr_out |-> $past(mode_wr_out))
        else $error("param write without mode write");
    AST_VEL_PARAM: assert property (mode_wr_out && axis_mode_out == AX_MODE_VELOCITY
        |=> axis_wr_out && param_num_out == PARAM_TARGET_VEL)
        else $error("velocity not written");
    AST_POS_PARAM: assert property (mode_wr_out && axis_mode_out != AX_MODE_VELOCITY
        |=> axis_wr_out && param_num_out == PARAM_TARGET_POS)
        else $error("position not written");
    AST_SAME_AXIS: assert property (axis_wr_out |-> $stable(axis_sel_out) && axis_sel_out < 3'h6)
        else $error("bad axis on write");
    AST_OK_REPLY: assert property (axis_wr_out |=> reply_out && reply_status_out == STATUS_OK)
        else $error("no ok reply");
    AST_REPLY_BOUND: assert property ($rose(busy_out) |-> ##[1:4] reply_out)
        else $error("reply late");
    AST_FREE_AT_REPLY: assert property (reply_out |-> !busy_out ##1 !reply_out)
        else $error("busy at reply");
    AST_WRITE_BUSY: assert property (mode_wr_out |-> busy_out && !axis_wr_out && !reply_out)
        else $error("mode write outside frame");
    AST_MODE_CODE: assert property (mode_wr_out |-> axis_mode_out <= AX_MODE_POS_POINT)
        else $error("bad axis mode");
    cover property (mode_wr_out && axis_mode_out == AX_MODE_VELOCITY && dir_left_out);
    cover property (mode_wr_out && axis_mode_out == AX_MODE_POS_POINT);
    cover property (reply_out && reply_status_out == STATUS_BAD_VALUE);
endmodule // amd_decoder_props
bind amd_decoder amd_decoder_props amd_decoder_props_inst (.core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in), .rx_valid_in(rx_valid_in), .rx_byte_in(rx_byte_in),
    .accu_in(accu_in), .index_in(index_in), .axis_wr_out(axis_wr_out),
    .axis_sel_out(axis_sel_out), .param_num_out(param_num_out), .param_val_out(param_val_out),
    .mode_wr_out(mode_wr_out), .axis_mode_out(axis_mode_out), .dir_left_out(dir_left_out),
    .reply_out(reply_out), .reply_status_out(reply_status_out), .busy_out(busy_out));
`default_nettype wire

//--- test/tb_top.sv
// self-checking bench for the accumulator motion command decoder
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import amd_pkg::*;
    logic        core_clk_in = 1'b0;
    logic        rst_n_in    = 1'b0;
    logic        rx_valid_in;
    logic [7:0]  rx_byte_in;
    logic [31:0] accu_in     = 32'h0;
    logic [31:0] index_in    = 32'h0;
    logic        axis_wr_out, mode_wr_out, dir_left_out, reply_out, busy_out;
    logic [2:0]  axis_sel_out, axis_mode_out;
    logic [7:0]  param_num_out, reply_status_out;
    logic [31:0] param_val_out;
    int          fails  = 0;
    int          checks = 0;
    logic [7:0]  ops [5] = '{OP_ROT_LEFT, OP_ROT_RIGHT, OP_ROT_LEFT_IDX, OP_ROT_RIGHT_IDX,
                             OP_MOVE_POS_IDX};
    always #10 core_clk_in = ~core_clk_in;
    amd_decoder amd_decoder_inst (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
        .rx_valid_in(rx_valid_in), .rx_byte_in(rx_byte_in), .accu_in(accu_in),
        .index_in(index_in), .axis_wr_out(axis_wr_out), .axis_sel_out(axis_sel_out),
        .param_num_out(param_num_out), .param_val_out(param_val_out),
        .mode_wr_out(mode_wr_out), .axis_mode_out(axis_mode_out), .dir_left_out(dir_left_out),
        .reply_out(reply_out), .reply_status_out(reply_status_out), .busy_out(busy_out));
    amd_host amd_host_inst (.core_clk_in(core_clk_in), .busy_in(busy_out),
        .rx_valid_out(rx_valid_in), .rx_byte_out(rx_byte_in));
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp)
        begin
            fails++;
            $display("ERROR %0t %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // one frame through the decoder; expectations come from the integer model below
    task automatic run(input logic [7:0] op, typ, mot, input logic [31:0] idx, input bit bad,
                       input int gap);
        int          axis, lat, nm, np;
        logic [7:0]  st;
        logic [31:0] acc;
        bit          pos, direct;
        acc    = $urandom;
        if (op == OP_MOVE_POS_IDX) acc = acc >> 1; // move distance kept in 31 bits
        pos    = (op == OP_MOVE_POS_IDX);
        direct = (op == OP_ROT_LEFT || op == OP_ROT_RIGHT);
        axis   = direct ? int'(mot) : (idx > 32'h5 ? 6 : int'(idx));
        st = bad ? STATUS_BAD_SUM
           : !(pos || (op >= OP_ROT_LEFT && op <= OP_ROT_RIGHT_IDX)) ? STATUS_BAD_CMD
           : (pos && typ > MODE_STORED_POINT) ? STATUS_BAD_TYPE
           : axis > 5 ? STATUS_BAD_VALUE : STATUS_OK;
        nm  = 0;
        np  = 0;
        lat = 0;
        @(negedge core_clk_in) {accu_in, index_in} = {acc, idx};
        amd_host_inst.send(op, typ, mot, gap, bad);
        for (int i = 1; i <= 12 && lat == 0; i++)
        begin
            @(posedge core_clk_in) #1;
            if (mode_wr_out === 1'b1)
            begin
                nm++;
                check(i, 2, "mode cycle");
                check(axis_mode_out, pos ? AX_MODE_POS_ABS + typ[2:0] : AX_MODE_VELOCITY, "mode");
                check(axis_sel_out, axis, "axis");
                if (!pos) check(dir_left_out, op == OP_ROT_LEFT || op == OP_ROT_LEFT_IDX, "dir");
            end
            if (axis_wr_out === 1'b1)
            begin
                np++;
                check(param_num_out, pos ? PARAM_TARGET_POS : PARAM_TARGET_VEL, "param");
                check(param_val_out, acc, "value");
            end
            if (reply_out === 1'b1) lat = i;
        end
        check(lat, st == STATUS_OK ? 4 : 2, "reply time");
        if (lat == 0) complete_run();
        check(reply_status_out, st, "status");
        check(nm, st == STATUS_OK ? 1 : 0, "mode writes");
        check(np, st == STATUS_OK ? 1 : 0, "param writes");
    endtask
    initial
    begin
        accu_in = $urandom(32'hBBFCBA2D);
        repeat (10) @(negedge core_clk_in);
        rst_n_in = 1'b1;
        // every opcode and move mode; don't-care fields random, slow host on odd runs
        for (int k = 0; k < 15; k++)
            run(ops[k % 5], k % 5 == 4 ? 8'(k % 3) : 8'($urandom), 8'($urandom_range(5)),
                32'($urandom_range(5)), 1'b0, k % 2);
        $display("test commands done");
        run(OP_ROT_LEFT_IDX, 8'h00, 8'h00, 32'h6, 1'b0, 0);
        run(OP_MOVE_POS_IDX, 8'h00, 8'h00, 32'h100, 1'b0, 0);
        run(OP_ROT_RIGHT, 8'h00, 8'h06, 32'h0, 1'b0, 0);
        run(OP_MOVE_POS_IDX, 8'h03, 8'h00, 32'h1, 1'b0, 0);
        run(OP_ROT_LEFT, 8'h00, 8'h01, 32'h0, 1'b1, 0);
        run(8'h2E, 8'h00, 8'h00, 32'h0, 1'b0, 1);
        $display("test refusals done");
        @(negedge core_clk_in) rst_n_in = 1'b0;
        @(negedge core_clk_in) check({busy_out, reply_out, mode_wr_out, axis_wr_out}, 0, "rst");
        check(reply_status_out, STATUS_OK, "rst status");
        rst_n_in = 1'b1;
        run(OP_MOVE_POS_IDX, 8'h02, 8'h00, 32'h3, 1'b0, 0);
        run(OP_ROT_RIGHT_IDX, 8'h00, 8'h00, 32'h3, 1'b0, 0);
        $display("test reset and abort done");
        complete_run();
    end
endmodule // tb_top
`default_nettype wire
